// *** logic/camh_msg_handler.sv ***
`timescale 1ns/1ps
module camh_msg_handler (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Incoming tokens
	input wire logic inValid,
	output logic inReady,
	input wire logic inCtrl,
	input wire logic [7:0] inData,
	input wire logic [31:0] inDest,
	// Outgoing reply tokens
	output logic outValid,
	input wire logic outReady,
	output logic outCtrl,
	output logic [7:0] outData,
	output logic [23:0] outDest,
	// Processor status port
	input wire logic psReq,
	input wire logic psWrite,
	input wire logic [31:0] psResId,
	input wire logic [31:0] psWdata,
	output logic psDone,
	output logic psErr,
	output logic [31:0] psRdata,
	// Register access port
	output logic accReq,
	output logic accWrite,
	output logic accByte,
	output logic [1:0] accSpace,
	output logic [15:0] accAddr,
	output logic [31:0] accWdata,
	input wire logic accAck,
	input wire logic accErr,
	input wire logic [31:0] accRdata
);
	typedef struct packed {
		camh_pkg::camh_state_t st;
		logic isWr;
		logic isPer;
		logic fail;
		logic [1:0] space;
		logic [23:0] rid;
		logic [15:0] regNum;
		logic [7:0] size;
		logic [2:0] cnt;
		logic [31:0] dataBuf;
	} camh_regs_t;

	camh_regs_t s_reg, s_next;
	logic take;
	logic txStart;
	logic txBusy;
	logic suppress;
	logic psBadId;
	logic [2:0] txBytes;

	assign suppress = s_reg.isWr && s_reg.rid[7:0] == camh_pkg::NO_REPLY_ID;
	assign psBadId = psResId[7:0] != camh_pkg::PS_RES_TYPE;
	assign inReady = ce && ((s_reg.st == camh_pkg::ST_IDLE && !psReq) || s_reg.st == camh_pkg::ST_RID ||
		s_reg.st == camh_pkg::ST_REGN || s_reg.st == camh_pkg::ST_SIZE || s_reg.st == camh_pkg::ST_DATA ||
		s_reg.st == camh_pkg::ST_END);
	assign take = inValid && inReady;
	assign accReq = ce && ((s_reg.st == camh_pkg::ST_ACC) || (s_reg.st == camh_pkg::ST_PSACC && !psBadId));
	assign accWrite = s_reg.st == camh_pkg::ST_PSACC ? psWrite : s_reg.isWr;
	assign accByte = s_reg.st == camh_pkg::ST_ACC && s_reg.isPer;
	assign accSpace = s_reg.st == camh_pkg::ST_PSACC ? camh_pkg::SPACE_PS : s_reg.space;
	assign accAddr = s_reg.st == camh_pkg::ST_PSACC ? psResId[23:8] : s_reg.regNum;
	assign accWdata = s_reg.st == camh_pkg::ST_PSACC ? psWdata :
		(s_reg.isPer ? {24'h00_0000, s_reg.dataBuf[31:24]} : s_reg.dataBuf);
	assign txStart = ce && s_reg.st == camh_pkg::ST_REPLY && !suppress && !txBusy;
	assign txBytes = s_reg.isWr ? 3'h0 : (s_reg.isPer ? s_reg.size[2:0] : camh_pkg::CFG_DATA_BYTES);
	assign psDone = ce && s_reg.st == camh_pkg::ST_PSDONE;
	assign psErr = s_reg.fail;
	assign psRdata = s_reg.dataBuf;

	always_comb begin
		s_next = s_reg;
		if (ce) begin
			case (s_reg.st)
				camh_pkg::ST_IDLE: begin
					if (psReq) begin
						s_next.fail = 1'b0;
						s_next.st = camh_pkg::ST_PSACC;
					end else if (take && inCtrl) begin
						s_next.cnt = camh_pkg::CNT_RESET;
						s_next.st = camh_pkg::ST_RID;
						s_next.isWr = inData == camh_pkg::TOK_CFG_WR || inData == camh_pkg::TOK_PER_WR;
						s_next.isPer = inData == camh_pkg::TOK_PER_WR || inData == camh_pkg::TOK_PER_RD;
						s_next.size = camh_pkg::PER_MAX_BYTES;
						s_next.space = inDest[15:0] == camh_pkg::DEST_NODE ? camh_pkg::SPACE_NODE : camh_pkg::SPACE_TILE;
						s_next.fail = 1'b0;
						if (inData == camh_pkg::TOK_PER_WR || inData == camh_pkg::TOK_PER_RD) begin
							s_next.space = camh_pkg::SPACE_PERIPH;
							s_next.fail = inDest[7:0] != camh_pkg::DEST_PERIPH;
						end else if (inData == camh_pkg::TOK_CFG_WR || inData == camh_pkg::TOK_CFG_RD) begin
							s_next.fail = inDest[15:0] != camh_pkg::DEST_TILE && inDest[15:0] != camh_pkg::DEST_NODE;
						end else begin
							s_next.fail = 1'b1;
						end
					end
				end
				camh_pkg::ST_RID: begin
					if (take && inCtrl) begin
						s_next.st = camh_pkg::ST_IDLE;
					end else if (take) begin
						s_next.rid = {s_reg.rid[15:0], inData};
						s_next.cnt = s_reg.cnt + 3'h1;
						if (s_reg.cnt == camh_pkg::RID_LAST) begin
							s_next.cnt = camh_pkg::CNT_RESET;
							s_next.st = camh_pkg::ST_REGN;
						end
					end
				end
				camh_pkg::ST_REGN: begin
					if (take && inCtrl) begin
						s_next.fail = 1'b1;
						s_next.st = inData == camh_pkg::TOK_END ? camh_pkg::ST_REPLY : camh_pkg::ST_END;
					end else if (take) begin
						s_next.regNum = s_reg.isPer ? {8'h00, inData} : {s_reg.regNum[7:0], inData};
						s_next.cnt = s_reg.cnt + 3'h1;
						if (s_reg.isPer || s_reg.cnt == camh_pkg::CFG_REG_LAST) begin
							s_next.cnt = camh_pkg::CNT_RESET;
							s_next.st = s_reg.isPer ? camh_pkg::ST_SIZE :
								(s_reg.isWr ? camh_pkg::ST_DATA : camh_pkg::ST_END);
						end
					end
				end
				camh_pkg::ST_SIZE: begin
					if (take && inCtrl) begin
						s_next.fail = 1'b1;
						s_next.st = inData == camh_pkg::TOK_END ? camh_pkg::ST_REPLY : camh_pkg::ST_END;
					end else if (take) begin
						s_next.size = inData;
						if (inData == 8'h00 || inData > camh_pkg::PER_MAX_BYTES) begin
							s_next.fail = 1'b1;
							s_next.st = camh_pkg::ST_END;
						end else begin
							s_next.st = s_reg.isWr ? camh_pkg::ST_DATA : camh_pkg::ST_END;
						end
					end
				end
				camh_pkg::ST_DATA: begin
					if (take && inCtrl) begin
						s_next.fail = 1'b1;
						s_next.st = inData == camh_pkg::TOK_END ? camh_pkg::ST_REPLY : camh_pkg::ST_END;
					end else if (take) begin
						s_next.dataBuf = {s_reg.dataBuf[23:0], inData};
						s_next.cnt = s_reg.cnt + 3'h1;
						if (8'(s_reg.cnt) == s_reg.size - 8'h01) begin
							s_next.dataBuf = {s_reg.dataBuf[23:0], inData} << (8 * (camh_pkg::PER_MAX_BYTES - s_reg.size));
							s_next.cnt = camh_pkg::CNT_RESET;
							s_next.st = camh_pkg::ST_END;
						end
					end
				end
				camh_pkg::ST_END: begin
					if (take && inCtrl && inData == camh_pkg::TOK_END) begin
						s_next.st = s_reg.fail ? camh_pkg::ST_REPLY : camh_pkg::ST_ACC;
					end else if (take) begin
						s_next.fail = 1'b1;
					end
				end
				camh_pkg::ST_ACC: begin
					if (accAck) begin
						s_next.cnt = s_reg.cnt + 3'h1;
						s_next.regNum = s_reg.regNum + 16'h0001;
						if (s_reg.isPer) begin
							s_next.dataBuf = s_reg.isWr ? {s_reg.dataBuf[23:0], 8'h00} : {s_reg.dataBuf[23:0], accRdata[7:0]};
						end else begin
							s_next.dataBuf = s_reg.isWr ? s_reg.dataBuf : accRdata;
						end
						if (accErr) begin
							s_next.fail = 1'b1;
							s_next.st = camh_pkg::ST_REPLY;
						end else if (!s_reg.isPer || 8'(s_reg.cnt) == s_reg.size - 8'h01) begin
							s_next.st = camh_pkg::ST_REPLY;
						end
					end
				end
				camh_pkg::ST_REPLY: begin
					if (suppress || !txBusy) begin
						s_next.st = camh_pkg::ST_IDLE;
					end
				end
				camh_pkg::ST_PSACC: begin
					if (psBadId) begin
						s_next.fail = 1'b1;
						s_next.st = camh_pkg::ST_PSDONE;
					end else if (accAck) begin
						s_next.fail = accErr;
						s_next.dataBuf = accRdata;
						s_next.st = camh_pkg::ST_PSDONE;
					end
				end
				camh_pkg::ST_PSDONE: begin
					s_next.st = camh_pkg::ST_IDLE;
				end
				default: begin
					s_next.st = camh_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '{st: camh_pkg::ST_IDLE, isWr: 1'b0, isPer: 1'b0, fail: 1'b0, space: camh_pkg::SPACE_TILE,
				rid: camh_pkg::RID_RESET, regNum: camh_pkg::REG_RESET, size: camh_pkg::SIZE_RESET,
				cnt: camh_pkg::CNT_RESET, dataBuf: camh_pkg::BUF_RESET};
		end else begin
			s_reg <= s_next;
		end
	end

	camh_reply_tx u_tx (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.start(txStart),
		.ok(!s_reg.fail),
		.nBytes(txBytes),
		.data(s_reg.dataBuf),
		.dest(s_reg.rid),
		.busy(txBusy),
		.outValid(outValid),
		.outReady(outReady),
		.outCtrl(outCtrl),
		.outData(outData),
		.outDest(outDest)
	);

	no_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_reg.st == camh_pkg::ST_REPLY && suppress |-> !txStart)
		else $error("reply sent for suppressed write");
	bad_token_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_reg.st == camh_pkg::ST_IDLE && !psReq && take && inCtrl && inData != camh_pkg::TOK_CFG_WR &&
		inData != camh_pkg::TOK_CFG_RD && inData != camh_pkg::TOK_PER_WR && inData != camh_pkg::TOK_PER_RD
		|=> s_reg.fail)
		else $error("unknown leading token not flagged");
	no_access_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
		accReq && s_reg.st == camh_pkg::ST_ACC |-> !s_reg.fail)
		else $error("access issued for failed request");
	rid_msb_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_reg.st == camh_pkg::ST_RID && take && !inCtrl |=> s_reg.rid[7:0] == $past(inData) &&
		s_reg.rid[15:8] == $past(s_reg.rid[7:0]))
		else $error("return id not shifted in msb first");
	ps_bad_id_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && s_reg.st == camh_pkg::ST_PSACC && psBadId |-> !accReq ##1 psErr)
		else $error("bad status id reached the register port");
	ps_word_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && s_reg.st == camh_pkg::ST_PSACC && accReq && accAck |=> psRdata == $past(accRdata))
		else $error("status read word not returned");
	per_size_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && s_reg.st == camh_pkg::ST_SIZE && take && !inCtrl && inData > camh_pkg::PER_MAX_BYTES |=> s_reg.fail)
		else $error("oversize peripheral request accepted");
	reply_dest_a: assert property (@(posedge clk) disable iff (sys_rst)
		txStart |=> outDest == $past(s_reg.rid))
		else $error("reply routed to wrong channel-end");
endmodule

// *** logic/camh_pkg.sv ***
package camh_pkg;
	// Control tokens
	localparam logic [7:0] TOK_CFG_WR = 8'hC0;
	localparam logic [7:0] TOK_CFG_RD = 8'hC1;
	localparam logic [7:0] TOK_PER_WR = 8'h24;
	localparam logic [7:0] TOK_PER_RD = 8'h25;
	localparam logic [7:0] TOK_END = 8'h01;
	localparam logic [7:0] TOK_ACK = 8'h03;
	localparam logic [7:0] TOK_NAK = 8'h04;
	// Destination decode
	localparam logic [15:0] DEST_TILE = 16'hC20C;
	localparam logic [15:0] DEST_NODE = 16'hC30C;
	localparam logic [7:0] DEST_PERIPH = 8'h02;
	localparam logic [7:0] PS_RES_TYPE = 8'h0B;
	localparam logic [7:0] NO_REPLY_ID = 8'hFF;
	// Field sizes in bytes, less one for RID_LAST and CFG_REG_LAST
	localparam logic [2:0] RID_LAST = 3'h2;
	localparam logic [2:0] CFG_REG_LAST = 3'h1;
	localparam logic [2:0] CFG_DATA_BYTES = 3'h4;
	localparam logic [7:0] PER_MAX_BYTES = 8'h04;
	// Access spaces
	localparam logic [1:0] SPACE_TILE = 2'h0;
	localparam logic [1:0] SPACE_NODE = 2'h1;
	localparam logic [1:0] SPACE_PERIPH = 2'h2;
	localparam logic [1:0] SPACE_PS = 2'h3;
	// Reset values
	localparam logic [31:0] BUF_RESET = 32'h0000_0000;
	localparam logic [23:0] RID_RESET = 24'h00_0000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [7:0] SIZE_RESET = 8'h00;
	localparam logic [2:0] CNT_RESET = 3'h0;
	localparam logic [53:0] TX_SH_RESET = 54'h0;

	typedef enum logic [3:0] {
		ST_IDLE, ST_RID, ST_REGN, ST_SIZE, ST_DATA, ST_END, ST_ACC, ST_REPLY, ST_PSACC, ST_PSDONE
	} camh_state_t;
endpackage

// *** logic/camh_reply_tx.sv ***
`timescale 1ns/1ps
module camh_reply_tx (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Load side
	input wire logic start,
	input wire logic ok,
	input wire logic [2:0] nBytes,
	input wire logic [31:0] data,
	input wire logic [23:0] dest,
	output logic busy,
	// Token stream out
	output logic outValid,
	input wire logic outReady,
	output logic outCtrl,
	output logic [7:0] outData,
	output logic [23:0] outDest
);
	typedef struct packed {
		logic [53:0] sh;
		logic [2:0] left;
		logic [23:0] dest;
	} camh_tx_t;

	camh_tx_t s_reg, s_next;

	always_comb begin
		int n;
		int i;
		n = 0;
		i = 0;
		s_next = s_reg;
		if (ce && start && s_reg.left == 3'h0) begin
			n = ok ? int'(nBytes) : 0;
			s_next.sh = camh_pkg::TX_SH_RESET;
			s_next.sh[53:45] = {1'b1, ok ? camh_pkg::TOK_ACK : camh_pkg::TOK_NAK};
			for (i = 0; i < 4; i++) begin
				if (i < n) begin
					s_next.sh[44 - 9 * i -: 9] = {1'b0, data[8 * (n - 1 - i) +: 8]};
				end
			end
			s_next.sh[44 - 9 * n -: 9] = {1'b1, camh_pkg::TOK_END};
			s_next.left = 3'(n + 2);
			s_next.dest = dest;
		end else if (ce && outValid && outReady) begin
			s_next.sh = {s_reg.sh[44:0], 9'h000};
			s_next.left = s_reg.left - 3'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '{sh: camh_pkg::TX_SH_RESET, left: camh_pkg::CNT_RESET, dest: camh_pkg::RID_RESET};
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy = s_reg.left != 3'h0;
	assign outValid = ce && s_reg.left != 3'h0;
	assign outCtrl = s_reg.sh[53];
	assign outData = s_reg.sh[52:45];
	assign outDest = s_reg.dest;

	sequence headTok(logic good);
		s_reg.left != 3'h0 && outCtrl && outData == (good ? camh_pkg::TOK_ACK : camh_pkg::TOK_NAK);
	endsequence

	reply_head_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && start && !busy |=> headTok($past(ok)))
		else $error("reply does not open with status token");
	reply_tail_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_reg.left == 3'h1 |-> outCtrl && outData == camh_pkg::TOK_END)
		else $error("reply does not close with end token");
	reply_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && start && !busy && ok |=> s_reg.left == $past(nBytes) + 3'h2)
		else $error("reply length does not match data size");
endmodule

// *** verif/camh_reg_backend.sv ***
`timescale 1ns/1ps
module camh_reg_backend (
	// Clock
	input wire logic clk,
	// Access port
	input wire logic accReq,
	input wire logic accWrite,
	input wire logic [1:0] accSpace,
	input wire logic [15:0] accAddr,
	input wire logic [31:0] accWdata,
	output logic accAck,
	output logic accErr,
	output logic [31:0] accRdata,
	// Answer delay in cycles
	input wire logic [1:0] delay
);
	logic [31:0] mem [0:3][0:15];
	logic [1:0] waitCnt;
	initial begin
		accAck = 1'b0;
		accErr = 1'b0;
		accRdata = 32'h0000_0000;
		waitCnt = 2'h0;
		for (int i = 0; i < 16; i++) begin
			for (int s = 0; s < 4; s++) begin
				mem[s][i] = 32'h0000_00A0 + 32'(i);
			end
		end
	end
	// Answers after a chosen delay; data is scrambled outside the answer cycle
	always @(negedge clk) begin
		accRdata <= (accReq && !accAck && waitCnt >= delay) ? mem[accSpace][accAddr[3:0]] : ~accRdata;
		if (accAck) begin
			accAck <= 1'b0;
			waitCnt <= 2'h0;
		end else if (accReq && waitCnt < delay) begin
			waitCnt <= waitCnt + 2'h1;
		end else if (accReq) begin
			accAck <= 1'b1;
			accErr <= accAddr > 16'h000F;
			if (accWrite && accAddr < 16'h0010) begin
				mem[accSpace][accAddr[3:0]] <= accWdata;
			end
		end
	end
endmodule

// *** verif/camh_msg_handler_tb.sv ***
`timescale 1ns/1ps
module camh_msg_handler_tb;
	typedef struct packed {
		logic [7:0] lead;
		logic [31:0] dest;
		logic [23:0] rid;
		logic [15:0] regn;
		logic [7:0] size;
		logic [31:0] data;
		logic ok;
		logic [2:0] nRep;
		logic [31:0] rep;
	} camh_row_t;
	logic clk, sys_rst, ce, inValid, inReady, inCtrl, outValid, outReady, outCtrl;
	logic [7:0] inData, outData;
	logic [31:0] inDest, curDest, psResId, psWdata, psRdata, accWdata, accRdata, rd;
	logic [23:0] outDest;
	logic psReq, psWrite, psDone, psErr, accReq, accWrite, accByte, accAck, accErr, stall, e;
	logic [1:0] accSpace, bdelay;
	logic [15:0] accAddr;
	logic [32:0] repQ[$];
	int nMismatch, checkCount;
	// Destinations keep the tile, node and peripheral forms, save one row with the unknown C40C form
	camh_row_t rows[15] = '{
		'{8'hC0, 32'h0001_C20C, 24'h01_2345, 16'h0003, 8'h00, 32'h1234_5678, 1, 0, 0},
		'{8'hC1, 32'h0001_C20C, 24'h01_2345, 16'h0003, 8'h00, 0, 1, 4, 32'h1234_5678},
		'{8'hC0, 32'h0002_C30C, 24'h02_11FF, 16'h0005, 8'h00, 32'hCAFE_F00D, 1, 0, 0},
		'{8'hC1, 32'h0002_C30C, 24'h02_1100, 16'h0005, 8'h00, 0, 1, 4, 32'hCAFE_F00D},
		'{8'hC1, 32'h0001_C20C, 24'h01_2345, 16'h0020, 8'h00, 0, 0, 0, 0},
		'{8'h55, 32'h0001_C20C, 24'h01_2345, 16'h0003, 8'h00, 0, 0, 0, 0},
		'{8'hC1, 32'h0001_C40C, 24'h01_2345, 16'h0003, 8'h00, 0, 0, 0, 0},
		'{8'h25, 32'h0002_0702, 24'h02_3400, 16'h0002, 8'h02, 0, 1, 2, 32'hA2A3_0000},
		'{8'h24, 32'h0002_0702, 24'h02_3400, 16'h0001, 8'h01, 32'h5A00_0000, 1, 0, 0},
		'{8'h25, 32'h0002_0702, 24'h02_3400, 16'h0002, 8'h05, 0, 0, 0, 0},
		'{8'hC0, 32'h0001_C20C, 24'h01_2345, 16'h0020, 8'h00, 32'h1111_2222, 0, 0, 0},
		'{8'h25, 32'h0002_0702, 24'h02_3400, 16'h000F, 8'h02, 0, 0, 0, 0},
		'{8'h25, 32'h0002_0702, 24'h02_3400, 16'h0001, 8'h01, 0, 1, 1, 32'h5A00_0000},
		'{8'h24, 32'h0002_0702, 24'h02_34FF, 16'h0004, 8'h03, 32'hB1B2_B300, 1, 0, 0},
		'{8'h25, 32'h0002_0702, 24'h02_3400, 16'h0004, 8'h03, 0, 1, 3, 32'hB1B2_B300}
	};
	camh_msg_handler DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .inValid(inValid), .inReady(inReady),
		.inCtrl(inCtrl), .inData(inData), .inDest(inDest), .outValid(outValid), .outReady(outReady),
		.outCtrl(outCtrl), .outData(outData), .outDest(outDest), .psReq(psReq), .psWrite(psWrite),
		.psResId(psResId), .psWdata(psWdata), .psDone(psDone), .psErr(psErr), .psRdata(psRdata),
		.accReq(accReq), .accWrite(accWrite), .accByte(accByte), .accSpace(accSpace), .accAddr(accAddr),
		.accWdata(accWdata), .accAck(accAck), .accErr(accErr), .accRdata(accRdata));
	camh_reg_backend backend (.clk(clk), .accReq(accReq), .accWrite(accWrite), .accSpace(accSpace),
		.accAddr(accAddr), .accWdata(accWdata), .accAck(accAck), .accErr(accErr), .accRdata(accRdata),
		.delay(bdelay));
	always #4 clk = ~clk;
	// Reply sink, optionally stalling every other cycle
	always @(negedge clk) begin
		outReady <= stall ? ~outReady : 1'b1;
	end
	always @(posedge clk) begin
		if (outValid && outReady) begin
			repQ.push_back({outCtrl, outDest, outData});
		end
	end
	// Peripheral accesses are byte wide, all others word wide
	always @(posedge clk) begin
		if (accReq && accAck) begin
			chk(accByte, accSpace == camh_pkg::SPACE_PERIPH);
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic send_tok(input logic c, input logic [7:0] d);
		int n;
		@(negedge clk);
		inValid = 1'b1;
		inCtrl = c;
		inData = d;
		inDest = curDest;
		n = 0;
		while (!inReady && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n == 300) begin
			nMismatch++;
			$display("CHECK FAILED at %0t: input never ready", $time);
		end
		@(posedge clk);
	endtask
	task automatic send_msg(input camh_row_t r);
		int nd;
		curDest = r.dest;
		nd = r.lead == 8'hC0 ? 4 : (r.lead == 8'h24 ? int'(r.size) : 0);
		send_tok(1'b1, r.lead);
		for (int i = 2; i >= 0; i--) begin
			send_tok(1'b0, r.rid[8*i +: 8]);
		end
		if (r.lead[7:4] != 4'h2) begin
			send_tok(1'b0, r.regn[15:8]);
		end
		send_tok(1'b0, r.regn[7:0]);
		if (r.lead[7:4] == 4'h2) begin
			send_tok(1'b0, r.size);
		end
		for (int i = 0; i < nd; i++) begin
			send_tok(1'b0, r.data[31-8*i -: 8]);
		end
		send_tok(1'b1, 8'h01);
		@(negedge clk);
		inValid = 1'b0;
	endtask
	task automatic expect_reply(input camh_row_t r);
		logic [32:0] q[$];
		int n;
		q.push_back({1'b1, r.rid, r.ok ? camh_pkg::TOK_ACK : camh_pkg::TOK_NAK});
		for (int i = 0; i < r.nRep; i++) begin
			q.push_back({1'b0, r.rid, r.rep[31-8*i -: 8]});
		end
		q.push_back({1'b1, r.rid, camh_pkg::TOK_END});
		if ((r.lead == 8'hC0 || r.lead == 8'h24) && r.rid[7:0] == 8'hFF) begin
			q.delete();
		end
		n = 0;
		while ((n < 60 || repQ.size() < q.size()) && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(repQ.size(), q.size());
		if (repQ.size() == q.size()) begin
			foreach (q[i]) begin
				chk(repQ.pop_front(), q[i]);
			end
		end
		repQ.delete();
	endtask
	task automatic ps_op(input logic w, input logic [31:0] id, input logic [31:0] wd);
		int n;
		@(negedge clk);
		psReq = 1'b1;
		psWrite = w;
		psResId = id;
		psWdata = wd;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (psDone !== 1'b1 && n < 100);
		chk(psDone, 1'b1);
		e = psErr;
		rd = psRdata;
		@(negedge clk);
		psReq = 1'b0;
	endtask
	initial begin
		#400000;
		nMismatch++;
		wrap_up();
	end
	initial begin
		{clk, ce, sys_rst} = 3'b111;
		{inValid, inCtrl, inData, psReq, psWrite, stall, bdelay} = '0;
		{inDest, curDest, psResId, psWdata} = '0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			stall = i[0];
			bdelay = 2'(i % 3);
			send_msg(rows[i]);
			expect_reply(rows[i]);
			$display("Row test %0d done", i);
		end
		// Reset in the middle of a message, then a clean read
		curDest = 32'h0001_C20C;
		send_tok(1'b1, 8'hC1);
		send_tok(1'b0, 8'h01);
		@(negedge clk);
		sys_rst = 1'b1;
		inValid = 1'b0;
		repeat (2) @(negedge clk);
		chk({inReady, outValid, accReq, psDone, psErr, psRdata, outDest}, {1'b1, 4'h0, 32'h0000_0000, 24'h00_0000});
		sys_rst = 1'b0;
		send_msg(rows[1]);
		expect_reply(rows[1]);
		$display("Mid-message reset test done");
		// Clock enable low freezes the block and masks its handshakes
		@(negedge clk);
		ce = 1'b0;
		psReq = 1'b1;
		psResId = 32'h0000_020B;
		repeat (3) @(negedge clk);
		chk({inReady, accReq, psDone, outValid}, 4'h0);
		psReq = 1'b0;
		ce = 1'b1;
		@(negedge clk);
		chk({inReady, accReq}, 2'h2);
		$display("Clock enable test done");
		// Status register access by resource id
		ps_op(1'b1, 32'h0000_020B, 32'h0BAD_CAFE);
		chk(e, 1'b0);
		ps_op(1'b0, 32'h0000_020B, 32'h0000_0000);
		chk({e, rd}, {1'b0, 32'h0BAD_CAFE});
		ps_op(1'b1, 32'h0000_020C, 32'h0000_0001);
		chk(e, 1'b1);
		ps_op(1'b0, 32'h0000_200B, 32'h0000_0000);
		chk(e, 1'b1);
		$display("Status access test done");
		wrap_up();
	end
endmodule
